// ===== include/pasr_pkg.sv
/*
 * Constants for the PHY advertisement and special control register bank.
 * Assumes a 32-bit classic Wishbone host bus; each register index is
 * four times smaller than its byte address.
 */
package pasr_pkg;
   // Register indices; byte address is index times four
   localparam logic [7:0] PHY2_IDENT_HIGH_IDX        = 8'h5e;
   localparam logic [7:0] PHY2_AUTONEG_ADVERTISE_IDX = 8'h60;
   localparam logic [7:0] PHY2_PARTNER_ABILITY_IDX   = 8'h62;
   localparam logic [7:0] RESERVED_A_IDX             = 8'h64;
   localparam logic [7:0] PHY1_SPECIAL_CTRL_IDX      = 8'h66;
   localparam logic [7:0] RESERVED_B_IDX             = 8'h68;
   localparam logic [7:0] PHY2_SPECIAL_CTRL_IDX      = 8'h6a;

   localparam int unsigned ADR_W = 10;
   localparam int unsigned REG_W = 16;

   // Advertisement word fields
   localparam int unsigned ADV_PAUSE_BIT  = 10;
   localparam int unsigned ADV_RSVD9_BIT  = 9;
   localparam int unsigned ADV_ABIL_LSB   = 5;
   localparam int unsigned ADV_ABIL_W     = 4;
   localparam logic [4:0]  ADV_SELECTOR   = 5'h01;
   localparam logic        ADV_PAUSE_RST  = 1'b1;
   localparam logic [3:0]  ADV_ABIL_RST   = 4'hf;
   localparam logic        ADV_RSVD9_RST  = 1'b0;

   // Partner ability word fields
   localparam int unsigned LP_PAUSE_BIT   = 10;
   localparam int unsigned LP_ABIL_LSB    = 5;
   localparam logic [4:0]  LP_RSVD_LOW    = 5'h01;

   // Control word four alias positions
   localparam int unsigned CR4_PAUSE_BIT  = 4;
   localparam int unsigned CR4_W          = 5;

   // Port status word positions
   localparam int unsigned STS_POL_BIT    = 13;
   localparam int unsigned STS_MDIX_BIT   = 7;
   localparam int unsigned STS_LP_W       = 5;

   // Special control word fields
   localparam int unsigned SPC_POL_BIT    = 5;
   localparam int unsigned SPC_MDIX_BIT   = 4;
   localparam int unsigned SPC_FORCE_BIT  = 3;
   localparam int unsigned SPC_EEE_BIT    = 2;
   localparam int unsigned SPC_LOOP_BIT   = 1;
   localparam int unsigned SPC_RSVD0_BIT  = 0;
   localparam logic        SPC_FORCE_RST  = 1'b0;
   localparam logic        SPC_EEE_RST    = 1'b1;
   localparam logic        SPC_LOOP_RST   = 1'b0;
   localparam logic        SPC_RSVD0_RST  = 1'b0;
endpackage : pasr_pkg

// ===== hdl/pasr_wb_slave.sv
/*
 * Classic Wishbone slave front end: one registered ack per request.
 * Assumes a master that holds the request until it samples ack.
 */
`timescale 1ns/10ps
module pasr_wb_slave
   import pasr_pkg::*;
(
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   input  wire logic             cyc_i,
   input  wire logic             stb_i,
   input  wire logic             we_i,
   input  wire logic [ADR_W-1:0] adr_i,
   output logic                  ack_o,
   output logic                  load_o,
   output logic                  wr_o,
   output logic [7:0]            idx_o
);
   logic ack;
   logic next_ack;

   // Ack drops the cycle after it was given, so no double answer
   always_comb begin
      next_ack = cyc_i & stb_i & ~ack;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack <= 1'b0;
      end else begin
         ack <= next_ack;
      end
   end

   assign ack_o  = ack;
   assign load_o = next_ack;
   assign wr_o   = ack & cyc_i & stb_i & we_i;
   assign idx_o  = adr_i[ADR_W-1:2];
endmodule : pasr_wb_slave

// ===== hdl/pasr_phy_special.sv
/*
 * One PHY special control and status word with its alias port.
 * Assumes status bits arrive from logic on the same clock.
 */
`timescale 1ns/10ps
module pasr_phy_special
   import pasr_pkg::*;
(
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   input  wire logic             bus_wr_i,
   input  wire logic             bus_lo_i,
   input  wire logic [REG_W-1:0] bus_wdata_i,
   input  wire logic             alias_wr_i,
   input  wire logic             alias_force_i,
   input  wire logic             alias_loop_i,
   input  wire logic [REG_W-1:0] status_word_i,
   output logic [REG_W-1:0]      rdata_o,
   output logic                  force_link_o,
   output logic                  loopback_o,
   output logic                  eee_enable_o
);
   logic force_link;
   logic eee_off;
   logic loopback;
   logic rsvd0;
   logic next_force_link;
   logic next_eee_off;
   logic next_loopback;
   logic next_rsvd0;

   always_comb begin
      next_force_link = force_link;
      next_eee_off    = eee_off;
      next_loopback   = loopback;
      next_rsvd0      = rsvd0;
      // Alias first, so a same-cycle bus write wins
      if (alias_wr_i) begin
         next_force_link = alias_force_i;
         next_loopback   = alias_loop_i;
      end
      if (bus_wr_i && bus_lo_i) begin
         next_force_link = bus_wdata_i[SPC_FORCE_BIT];
         next_eee_off    = bus_wdata_i[SPC_EEE_BIT];
         next_loopback   = bus_wdata_i[SPC_LOOP_BIT];
         next_rsvd0      = bus_wdata_i[SPC_RSVD0_BIT];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         force_link <= SPC_FORCE_RST;
         eee_off    <= SPC_EEE_RST;
         loopback   <= SPC_LOOP_RST;
         rsvd0      <= SPC_RSVD0_RST;
      end else begin
         force_link <= next_force_link;
         eee_off    <= next_eee_off;
         loopback   <= next_loopback;
         rsvd0      <= next_rsvd0;
      end
   end

   always_comb begin
      rdata_o                = '0;
      rdata_o[SPC_POL_BIT]   = status_word_i[STS_POL_BIT];
      rdata_o[SPC_MDIX_BIT]  = status_word_i[STS_MDIX_BIT];
      rdata_o[SPC_FORCE_BIT] = force_link;
      rdata_o[SPC_EEE_BIT]   = eee_off;
      rdata_o[SPC_LOOP_BIT]  = loopback;
      rdata_o[SPC_RSVD0_BIT] = rsvd0;
   end

   assign force_link_o = force_link;
   assign loopback_o   = loopback;
   assign eee_enable_o = ~eee_off;
endmodule : pasr_phy_special

// ===== hdl/pasr_regs.sv
/*
 * Host-visible port 2 identifier high word, port 2 advertisement and
 * partner ability words, and the two PHY special control words.
 * Assumes a classic Wishbone master on the same clock, and port status
 * and alias write strobes from switch logic on the same clock.
 */
// Operation
// - Port 2 identifier high word is read-only; writes leave it unchanged.
// - Advertise pause bit 10 resets to 1, shares storage with control four bit 4.
// - Advertise bits 8..5 reset to 1, share control four bits 3..0.
// - Advertise next page and remote fault read 0; bits 14, 12-11, 9 reserved.
// - Partner bits 10, 8..5 read-only, mirror port 2 status bits 4..0.
// - Partner next page, ack, remote fault read 0; bits 4-0 read 0x01.
// - Special word bit 5 shows reversed receive polarity from status bit 13.
// - Special word bit 4 shows MDI-X state from status bit 7.
// - Special word bit 3 forces link pass, resets 0, aliases crossover bit 11.
// - Special word bit 2 resets 1; 1 disables energy efficient 10BT mode.
// - PHY 1 bit 1 loops port 1 receive to transmit, aliases bit 9.
// - PHY 2 bit 1 loops port 2 receive to transmit, aliases bit 9.
// - Special word bits 15-6 read zero; bit 0 reserved.
`timescale 1ns/10ps
module pasr_regs
   import pasr_pkg::*;
#(
   // Value is arbitrary
   parameter logic [REG_W-1:0] PHY2_IDENT_HIGH = 16'h5a5a
)
(
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   input  wire logic             wb_cyc_i,
   input  wire logic             wb_stb_i,
   input  wire logic             wb_we_i,
   input  wire logic [ADR_W-1:0] wb_adr_i,
   input  wire logic [3:0]       wb_sel_i,
   input  wire logic [31:0]      wb_dat_i,
   output logic [31:0]           wb_dat_o,
   output logic                  wb_ack_o,
   input  wire logic [REG_W-1:0] port1_status_word_i,
   input  wire logic [REG_W-1:0] port2_status_word_i,
   input  wire logic             port2_cr4_wr_i,
   input  wire logic [CR4_W-1:0] port2_cr4_wdata_i,
   output logic [CR4_W-1:0]      port2_cr4_adv_o,
   input  wire logic             port1_xover_wr_i,
   input  wire logic             port1_xover_force_i,
   input  wire logic             port1_xover_loop_i,
   input  wire logic             port2_xover_wr_i,
   input  wire logic             port2_xover_force_i,
   input  wire logic             port2_xover_loop_i,
   output logic                  port1_force_link_o,
   output logic                  port1_loopback_o,
   output logic                  port1_eee_enable_o,
   output logic                  port2_force_link_o,
   output logic                  port2_loopback_o,
   output logic                  port2_eee_enable_o
);
   logic             bus_load;
   logic             bus_wr;
   logic [7:0]       bus_idx;
   logic [REG_W-1:0] wdata;

   logic             adv_pause;
   logic [3:0]       adv_abil;
   logic             adv_rsvd9;
   logic             next_adv_pause;
   logic [3:0]       next_adv_abil;
   logic             next_adv_rsvd9;

   logic [31:0]      rdata;
   logic [31:0]      next_rdata;

   logic [REG_W-1:0] adv_word;
   logic [REG_W-1:0] lp_word;

   logic [1:0]       spc_wr;
   logic [1:0]       alias_wr;
   logic [1:0]       alias_force;
   logic [1:0]       alias_loop;
   logic [REG_W-1:0] status_word [2];
   logic [REG_W-1:0] spc_rdata   [2];
   logic [1:0]       force_link;
   logic [1:0]       loopback;
   logic [1:0]       eee_enable;

   // Index match used by every write decode and by the read mux
   function automatic logic hit(input logic [7:0] idx, input logic [7:0] reg_idx);
      hit = (idx == reg_idx);
   endfunction : hit

   pasr_wb_slave u_wb (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .cyc_i  (wb_cyc_i),
      .stb_i  (wb_stb_i),
      .we_i   (wb_we_i),
      .adr_i  (wb_adr_i),
      .ack_o  (wb_ack_o),
      .load_o (bus_load),
      .wr_o   (bus_wr),
      .idx_o  (bus_idx)
   );

   assign wdata = wb_dat_i[REG_W-1:0];

   // Advertisement storage, shared with control word four
   always_comb begin
      next_adv_pause = adv_pause;
      next_adv_abil  = adv_abil;
      next_adv_rsvd9 = adv_rsvd9;
      if (port2_cr4_wr_i) begin
         next_adv_pause = port2_cr4_wdata_i[CR4_PAUSE_BIT];
         next_adv_abil  = port2_cr4_wdata_i[ADV_ABIL_W-1:0];
      end
      // Bus write last, so it wins a collision with the alias
      if (bus_wr && hit(bus_idx, PHY2_AUTONEG_ADVERTISE_IDX)) begin
         if (wb_sel_i[1]) begin
            next_adv_pause = wdata[ADV_PAUSE_BIT];
            next_adv_rsvd9 = wdata[ADV_RSVD9_BIT];
            next_adv_abil[3] = wdata[ADV_ABIL_LSB+3];
         end
         if (wb_sel_i[0]) begin
            next_adv_abil[2:0] = wdata[ADV_ABIL_LSB+2:ADV_ABIL_LSB];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         adv_pause <= ADV_PAUSE_RST;
         adv_abil  <= ADV_ABIL_RST;
         adv_rsvd9 <= ADV_RSVD9_RST;
      end else begin
         adv_pause <= next_adv_pause;
         adv_abil  <= next_adv_abil;
         adv_rsvd9 <= next_adv_rsvd9;
      end
   end

   assign port2_cr4_adv_o = {adv_pause, adv_abil};

   // Next page, remote fault and reserved bits 14, 12-11 stay zero; reserved bit 9 is stored
   always_comb begin
      adv_word                = '0;
      adv_word[ADV_PAUSE_BIT] = adv_pause;
      adv_word[ADV_RSVD9_BIT] = adv_rsvd9;
      adv_word[ADV_ABIL_LSB +: ADV_ABIL_W] = adv_abil;
      adv_word[4:0]           = ADV_SELECTOR;
   end

   // Partner word is a live view of the port 2 status
   always_comb begin
      lp_word               = '0;
      lp_word[LP_PAUSE_BIT] = port2_status_word_i[CR4_PAUSE_BIT];
      lp_word[LP_ABIL_LSB +: ADV_ABIL_W] =
         port2_status_word_i[ADV_ABIL_W-1:0];
      lp_word[4:0]          = LP_RSVD_LOW;
   end

   assign status_word[0] = port1_status_word_i;
   assign status_word[1] = port2_status_word_i;
   assign alias_wr       = {port2_xover_wr_i, port1_xover_wr_i};
   assign alias_force    = {port2_xover_force_i, port1_xover_force_i};
   assign alias_loop     = {port2_xover_loop_i, port1_xover_loop_i};

   // Special bits all sit in the low byte, so only lane 0 matters
   assign spc_wr[0] = bus_wr & hit(bus_idx, PHY1_SPECIAL_CTRL_IDX);
   assign spc_wr[1] = bus_wr & hit(bus_idx, PHY2_SPECIAL_CTRL_IDX);

   generate
      for (genvar p = 0; p < 2; p++) begin : g_phy
         pasr_phy_special u_spc (
            .clk_i         (clk_i),
            .rst_i         (rst_i),
            .bus_wr_i      (spc_wr[p]),
            .bus_lo_i      (wb_sel_i[0]),
            .bus_wdata_i   (wdata),
            .alias_wr_i    (alias_wr[p]),
            .alias_force_i (alias_force[p]),
            .alias_loop_i  (alias_loop[p]),
            .status_word_i (status_word[p]),
            .rdata_o       (spc_rdata[p]),
            .force_link_o  (force_link[p]),
            .loopback_o    (loopback[p]),
            .eee_enable_o  (eee_enable[p])
         );
      end
   endgenerate

   assign port1_force_link_o = force_link[0];
   assign port2_force_link_o = force_link[1];
   assign port1_loopback_o   = loopback[0];
   assign port2_loopback_o   = loopback[1];
   assign port1_eee_enable_o = eee_enable[0];
   assign port2_eee_enable_o = eee_enable[1];

   // Read data captured as ack rises; unmapped and reserved read zero
   always_comb begin
      next_rdata = rdata;
      if (bus_load) begin
         next_rdata = '0;
         if (!wb_we_i) begin
            unique case (1'b1)
               hit(bus_idx, PHY2_IDENT_HIGH_IDX):
                  next_rdata[REG_W-1:0] = PHY2_IDENT_HIGH;
               hit(bus_idx, PHY2_AUTONEG_ADVERTISE_IDX):
                  next_rdata[REG_W-1:0] = adv_word;
               hit(bus_idx, PHY2_PARTNER_ABILITY_IDX):
                  next_rdata[REG_W-1:0] = lp_word;
               hit(bus_idx, PHY1_SPECIAL_CTRL_IDX):
                  next_rdata[REG_W-1:0] = spc_rdata[0];
               hit(bus_idx, PHY2_SPECIAL_CTRL_IDX):
                  next_rdata[REG_W-1:0] = spc_rdata[1];
               default:
                  next_rdata = '0;
            endcase
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdata <= '0;
      end else begin
         rdata <= next_rdata;
      end
   end

   assign wb_dat_o = rdata;
endmodule : pasr_regs

// ===== sim/pasr_checker.sv
/* Port assertions for the PHY register bank.
   Assumes a bind onto pasr_regs and a master that holds each request until ack. */
`timescale 1ns/10ps
module pasr_checker
   import pasr_pkg::*;
#(
   parameter logic [REG_W-1:0] PHY2_IDENT_HIGH = 16'h5a5a
)
(
   input logic             clk_i,
   input logic             rst_i,
   input logic             wb_cyc_i,
   input logic             wb_stb_i,
   input logic             wb_we_i,
   input logic [ADR_W-1:0] wb_adr_i,
   input logic [3:0]       wb_sel_i,
   input logic [31:0]      wb_dat_i,
   input logic [31:0]      wb_dat_o,
   input logic             wb_ack_o,
   input logic [REG_W-1:0] port1_status_word_i,
   input logic [REG_W-1:0] port2_status_word_i,
   input logic             port2_cr4_wr_i,
   input logic [CR4_W-1:0] port2_cr4_wdata_i,
   input logic [CR4_W-1:0] port2_cr4_adv_o,
   input logic             port1_xover_wr_i,
   input logic             port1_xover_force_i,
   input logic             port1_xover_loop_i,
   input logic             port2_xover_wr_i,
   input logic             port2_xover_loop_i,
   input logic             port1_force_link_o,
   input logic             port1_loopback_o,
   input logic             port1_eee_enable_o,
   input logic             port2_loopback_o,
   input logic             port2_eee_enable_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic bw;
   // Bus write lands at the ack edge, and beats an alias strobe there
   assign bw = wb_ack_o & wb_we_i & wb_cyc_i & wb_stb_i;
   sequence s_rd(logic [7:0] ix);
      wb_ack_o && !wb_we_i && wb_adr_i[9:2] == ix;
   endsequence
   chk_ack_pulse: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
      else $error("ack not a one cycle answer");
   chk_reset_vals: assert property (disable iff (1'b0) rst_i |=> !wb_ack_o &&
      port2_cr4_adv_o == 5'h1f && !port1_eee_enable_o && !port2_eee_enable_o && !port1_force_link_o)
      else $error("reset values wrong");
   chk_ident_read: assert property (s_rd(8'h5e) |-> wb_dat_o == {16'h0, PHY2_IDENT_HIGH})
      else $error("ident word wrong");
   chk_rsvd_zero: assert property (wb_ack_o && !wb_we_i &&
      (wb_adr_i[9:2] == 8'h64 || wb_adr_i[9:2] == 8'h68) |-> wb_dat_o == 32'h0)
      else $error("reserved offset not zero");
   chk_partner_word: assert property (s_rd(8'h62) |-> wb_dat_o[15:0] == {5'h0,
      $past(port2_status_word_i[4]), 1'b0, $past(port2_status_word_i[3:0]), 5'h01})
      else $error("partner word wrong");
   chk_adv_word: assert property (s_rd(8'h60) |-> wb_dat_o[15:11] == 5'h0 &&
      wb_dat_o[10] == $past(port2_cr4_adv_o[4]) &&
      wb_dat_o[8:0] == {$past(port2_cr4_adv_o[3:0]), 5'h01})
      else $error("advertisement word wrong");
   chk_spc1_word: assert property (s_rd(8'h66) |-> wb_dat_o[15:1] == {10'h0,
      $past(port1_status_word_i[13]), $past(port1_status_word_i[7]),
      $past(port1_force_link_o), !$past(port1_eee_enable_o), $past(port1_loopback_o)})
      else $error("phy1 special word wrong");
   chk_cr4_alias: assert property (port2_cr4_wr_i && !(bw && wb_adr_i[9:2] == 8'h60)
      |=> port2_cr4_adv_o == $past(port2_cr4_wdata_i))
      else $error("control four alias lost");
   chk_xover1_alias: assert property (port1_xover_wr_i && !(bw && wb_adr_i[9:2] == 8'h66)
      |=> port1_force_link_o == $past(port1_xover_force_i) &&
      port1_loopback_o == $past(port1_xover_loop_i))
      else $error("phy1 alias lost");
   chk_xover2_alias: assert property (port2_xover_wr_i && !(bw && wb_adr_i[9:2] == 8'h6a)
      |=> port2_loopback_o == $past(port2_xover_loop_i))
      else $error("phy2 alias lost");
   chk_spc1_write: assert property (bw && wb_adr_i[9:2] == 8'h66 && wb_sel_i[0]
      |=> port1_eee_enable_o == !$past(wb_dat_i[2]) && port1_force_link_o == $past(wb_dat_i[3]))
      else $error("phy1 special write lost");
endmodule : pasr_checker

bind pasr_regs pasr_checker #(.PHY2_IDENT_HIGH(PHY2_IDENT_HIGH)) u_chk (
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .port1_status_word_i(port1_status_word_i),
   .port2_status_word_i(port2_status_word_i), .port2_cr4_wr_i(port2_cr4_wr_i),
   .port2_cr4_wdata_i(port2_cr4_wdata_i), .port2_cr4_adv_o(port2_cr4_adv_o),
   .port1_xover_wr_i(port1_xover_wr_i), .port1_xover_force_i(port1_xover_force_i),
   .port1_xover_loop_i(port1_xover_loop_i), .port2_xover_wr_i(port2_xover_wr_i),
   .port2_xover_loop_i(port2_xover_loop_i), .port1_force_link_o(port1_force_link_o),
   .port1_loopback_o(port1_loopback_o), .port1_eee_enable_o(port1_eee_enable_o),
   .port2_loopback_o(port2_loopback_o), .port2_eee_enable_o(port2_eee_enable_o));

// ===== sim/tb_phy_autoneg_special_ctrl_regs.sv
/* Self-checking bench for the PHY register bank: bus and alias traffic.
   Assumes pasr_regs with the checker bound to it; 100 MHz clock. */
`timescale 1ns/10ps
`define CHK(nm, ex, got) \
   tests_run++; \
   if ((got) !== (ex)) begin \
      $display("Error %s expected %h seen %h", nm, ex, got); \
      n_errors++; \
   end
module tb_phy_autoneg_special_ctrl_regs;
   localparam logic [15:0] IDENT = 16'h3c69; // Arbitrary value
   logic        clk_i = 0, rst_i = 1, cyc, stb, we, ack, c4w;
   logic        x1w, x1f, x1l, x2w, x2f, x2l, f1, l1, e1, f2, l2, e2;
   logic [9:0]  adr;
   logic [3:0]  sel;
   logic [31:0] wdat, dout, rdat;
   logic [15:0] sts1, sts2, adv, spc1, spc2;
   logic [4:0]  c4d, c4a;
   int          n_errors = 0, tests_run = 0, seed = 32'ha59d0829;
   logic [9:0]  map [7] = '{10'h178, 10'h180, 10'h188, 10'h190, 10'h198, 10'h1a0, 10'h1a8};
   always #5 clk_i = ~clk_i;
   pasr_regs #(.PHY2_IDENT_HIGH(IDENT)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
      .wb_dat_o(dout), .wb_ack_o(ack), .port1_status_word_i(sts1), .port2_status_word_i(sts2),
      .port2_cr4_wr_i(c4w), .port2_cr4_wdata_i(c4d), .port2_cr4_adv_o(c4a),
      .port1_xover_wr_i(x1w), .port1_xover_force_i(x1f), .port1_xover_loop_i(x1l),
      .port2_xover_wr_i(x2w), .port2_xover_force_i(x2f), .port2_xover_loop_i(x2l),
      .port1_force_link_o(f1), .port1_loopback_o(l1), .port1_eee_enable_o(e1),
      .port2_force_link_o(f2), .port2_loopback_o(l2), .port2_eee_enable_o(e2));
   function automatic logic [15:0] spc_rd(logic [15:0] s, logic [15:0] st);
      return (s & 16'h000f) | {10'h0, st[13], st[7], 4'h0};
   endfunction : spc_rd
   function automatic logic [15:0] exp_rd(int i);
      case (i)
         0: return IDENT;
         1: return adv | 16'h0001;
         2: return {5'h0, sts2[4], 1'b0, sts2[3:0], 5'h01};
         4: return spc_rd(spc1, sts1);
         6: return spc_rd(spc2, sts2);
         default: return 16'h0;
      endcase
   endfunction : exp_rd
   task automatic wb(logic w, logic [9:0] a, logic [31:0] d, logic [3:0] s);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= s;
      // No cycle limit here; only the watchdog ends a hung wait
      do begin
         @(posedge clk_i);
      end while (ack !== 1'b1);
      rdat = dout;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask : wb
   task automatic wr(int i, logic [31:0] d, logic [3:0] s);
      logic [15:0] m;
      m = {{8{s[1]}}, {8{s[0]}}} & 16'h07e0;
      wb(1'b1, map[i], d, s);
      if (i == 1) adv = (adv & ~m) | (d[15:0] & m);
      if (i == 4 && s[0]) spc1 = {12'h0, d[3:0]};
      if (i == 6 && s[0]) spc2 = {12'h0, d[3:0]};
   endtask : wr
   task automatic check_all;
      for (int i = 0; i < 7; i++) begin
         wb(1'b0, map[i], 32'h0, 4'hf);
         `CHK($sformatf("read %h", map[i]), {16'h0, exp_rd(i)}, rdat)
      end
      `CHK("advert alias", {adv[10], adv[8:5]}, c4a)
      `CHK("port1 ctrl", {spc1[3], spc1[1], ~spc1[2]}, {f1, l1, e1})
      `CHK("port2 ctrl", {spc2[3], spc2[1], ~spc2[2]}, {f2, l2, e2})
   endtask : check_all
   task automatic do_reset;
      rst_i <= 1'b1;
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      adv = 16'h05e0;
      spc1 = 16'h0004;
      spc2 = 16'h0004;
   endtask : do_reset
   task tally_and_finish;
      $display("Comparisons %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : tally_and_finish
   initial begin
      {cyc, stb, we, c4w, x1w, x1f, x1l, x2w, x2f, x2l} <= '0;
      {adr, sel, wdat, c4d} <= '0;
      sts1 <= 16'($random(seed));
      sts2 <= 16'($random(seed));
      do_reset;
      check_all;
      $display("test reset values done");
      // Ident, reserved and single-lane writes first, then random traffic
      wr(0, 32'hffffffff, 4'hf);
      wr(3, 32'hffffffff, 4'hf);
      wr(1, 32'h0, 4'h2);
      wr(4, 32'h0, 4'h2);
      check_all;
      for (int k = 0; k < 40; k++) begin
         @(posedge clk_i);
         sts1 <= 16'($random(seed));
         sts2 <= 16'($random(seed));
         wr({$random(seed)} % 7, $random(seed), 4'($random(seed)));
         check_all;
      end
      $display("test random bus writes done");
      for (int k = 0; k < 12; k++) begin
         @(posedge clk_i);
         {c4w, x1w, x2w} <= 3'b111;
         {c4d, x1f, x1l, x2f, x2l} <= 9'($random(seed));
         @(posedge clk_i);
         {c4w, x1w, x2w} <= 3'b000;
         {adv[10], adv[8:5]} = c4d;
         {spc1[3], spc1[1], spc2[3], spc2[1]} = {x1f, x1l, x2f, x2l};
         check_all;
      end
      $display("test alias writes done");
      do_reset;
      check_all;
      $display("test mid-run reset done");
      tally_and_finish;
   end
   initial begin
      #300us;
      n_errors++;
      $display("Error watchdog expected finish seen hang");
      tally_and_finish;
   end
endmodule : tb_phy_autoneg_special_ctrl_regs
